// [inc/dsc_alu_cfg.svh]
// Constants of the operand and ALU datapath
`ifndef DSC_ALU_CFG_SVH
`define DSC_ALU_CFG_SVH
`define DW           16
`define NREGS        16
`define W_IMPLICIT   4'h0
`define W_MUL_LO     4'h4
`define W_MUL_HI     4'h7
`define W_XPF_LO     4'h8
`define W_XPF_HI     4'h9
`define W_YPF_LO     4'hA
`define W_YPF_HI     4'hB
`define W_PF_INDEX   4'hC
`define ADDR_STEP    16'h0002
`define ACC_W        40
`define ACC_ALIGN    16
`define ADJ_ILLEGAL  3'h4
`endif

// [inc/dsc_alu_pkg.sv]
// Types of the operand and ALU datapath
package dsc_alu_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_ADD_WITH_CARRY_OP, OP_AND, OP_ASR1, OP_ASRW, OP_ASRL,
    OP_BIT_CLEAR_OP, OP_ADDACC, OP_MAC, OP_SQR, OP_DIV, OP_BRC
  } alu_op_t;
  typedef enum logic [2:0] {FM_FILE, FM_FILE_W0, FM_TEN_BIT_LITERAL, FM_REG, FM_FIVE_BIT_LITERAL} form_t;
  typedef enum logic [2:0] {
    AM_DIR, AM_IND, AM_POSTINC, AM_POSTDEC, AM_PREINC, AM_PREDEC, AM_BASEOFS
  } amode_t;
  typedef struct packed {
    logic       en;
    logic       sel_hi;
    logic       idx;
    logic [2:0] adj;
    logic [1:0] dst;
  } prefetch_t;
  typedef struct packed {
    logic        valid;
    alu_op_t     op;
    form_t       form;
    amode_t      src_mode;
    amode_t      dst_mode;
    logic [3:0]  wb;
    logic [3:0]  ws;
    logic [3:0]  wd;
    logic [9:0]  lit;
    logic [3:0]  shift;
    logic        acc_b;
    logic [3:0]  bit_idx;
    logic [15:0] file_data;
    prefetch_t   xpf;
    prefetch_t   ypf;
  } op_req_t;
  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } mcu_flags_t;
  typedef struct packed {
    logic oa;
    logic ob;
    logic sa;
    logic sb;
  } dsp_flags_t;
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } mem_req_t;
  typedef enum logic {ST_RUN = 1'b0, ST_BR_WAIT = 1'b1} seq_state_t;
endpackage : dsc_alu_pkg

// [verilog/dsc_operand_alu_datapath.sv]
// Operand selection and ALU datapath of the signal controller core
// Operation
// (RULE_01) Sixteen working registers for any operand role
// (RULE_02) Register 0 is the implicit working operand
// (RULE_03) Direct, indirect, post and pre adjust modes
// (RULE_04) Accumulator operands add base offset indirect mode
// (RULE_05) Divide pair uses direct registers only
// (RULE_06) Square accepts only registers 4 to 7
// (RULE_07) Multiply accepts six distinct pairs of 4-7
// (RULE_08) X prefetch from 8/9, adjust, 9+12, none
// (RULE_09) Y prefetch from 10/11, adjust, 11+12, none
// (RULE_10) Prefetched data lands only in registers 4-7
// (RULE_11) File add with register 0, five flags
// (RULE_12) Register and literal add forms, five flags
// (RULE_13) Shifted signed add to accumulator, DSP flags
// (RULE_14) Single shift keeps sign, updates C N OV Z
// (RULE_15) Register count shift updates only N Z
// (RULE_16) Literal count shift leaves C OV alone
// (RULE_17) Flags C DC N OV Z in status
// (RULE_18) Overflow and saturate flags per accumulator
// (RULE_19) AND forms take one cycle, N Z only
// (RULE_20) Bit clear by 4-bit index, no flags
// (RULE_21) Carry branch one or two cycles, no flags
`include "dsc_alu_cfg.svh"
module dsc_operand_alu_datapath
  import dsc_alu_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire op_req_t      req_i,
  output logic              ready_o,
  output mem_req_t          src_mem_o,
  input  wire logic [15:0]  src_rdata_i,
  output mem_req_t          dst_mem_o,
  output logic [15:0]       xpf_addr_o,
  output logic              xpf_rd_o,
  input  wire logic [15:0]  xpf_rdata_i,
  output logic [15:0]       ypf_addr_o,
  output logic              ypf_rd_o,
  input  wire logic [15:0]  ypf_rdata_i,
  output logic [15:0]       file_wdata_o,
  output logic              file_we_o,
  output mcu_flags_t        flags_o,
  output dsp_flags_t        dsp_flags_o,
  output logic [39:0]       acc_a_o,
  output logic [39:0]       acc_b_o,
  output logic              div_start_o,
  output logic [15:0]       div_dividend_o,
  output logic [15:0]       div_divisor_o,
  output logic              branch_taken_o,
  output logic              illegal_o,
  input  wire logic [3:0]   implicit_working_reg0_sel_i,
  output logic [15:0]       implicit_working_reg0_data_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] ea_f(amode_t m, logic [15:0] b, logic [15:0] o);
    unique case (m)
      AM_PREINC:  ea_f = b + `ADDR_STEP;
      AM_PREDEC:  ea_f = b - `ADDR_STEP;
      AM_BASEOFS: ea_f = b + o;
      default:    ea_f = b;
    endcase
  endfunction : ea_f

  function automatic logic [15:0] adj_f(amode_t m, logic [15:0] b);
    unique case (m)
      AM_POSTINC, AM_PREINC: adj_f = b + `ADDR_STEP;
      AM_POSTDEC, AM_PREDEC: adj_f = b - `ADDR_STEP;
      default:               adj_f = b;
    endcase
  endfunction : adj_f

  function automatic logic in_mul_f(logic [3:0] r);
    in_mul_f = (r >= `W_MUL_LO) && (r <= `W_MUL_HI);
  endfunction : in_mul_f

  // ************************************************************
  // State
  // ************************************************************
  logic [15:0] w_q [`NREGS];
  logic [15:0] w_d [`NREGS];
  logic [39:0] acc_q [2];
  mcu_flags_t  flags_q;
  dsp_flags_t  dsp_q;
  seq_state_t  state_q;

  // ************************************************************
  // Operand selection
  // ************************************************************
  op_req_t     r;
  logic        take;
  logic        bad;
  logic [15:0] src_ea;
  logic [15:0] dst_ea;
  logic [15:0] src_val;
  logic        src_mem;
  logic        dst_mem;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic        cin;
  logic [16:0] sum;
  logic [4:0]  nib;
  logic [15:0] res;
  logic        wr_res;
  logic [15:0] xbase;
  logic [15:0] ybase;
  logic        acc_upd;
  logic [39:0] addend;
  logic [40:0] acc_sum;
  logic        acc_sat;
  logic [39:0] acc_new;
  logic [31:0] prod;
  logic [39:0] wide_src;

  assign r = req_i;
  assign ready_o = (state_q == ST_RUN);
  assign src_mem = (r.src_mode != AM_DIR);
  assign dst_mem = (r.dst_mode != AM_DIR);
  assign src_ea  = ea_f(r.src_mode, w_q[r.ws], w_q[r.wb]);           // RULE_03 RULE_04
  assign dst_ea  = ea_f(r.dst_mode, w_q[r.wd], w_q[r.wb]);           // RULE_03 RULE_04
  assign src_val = src_mem ? src_rdata_i : w_q[r.ws];                // RULE_01

  // Prefetch addresses come from the pointer registers, with register 12 added to 9 or 11 when indexed
  assign xbase = r.xpf.sel_hi ? w_q[`W_XPF_HI] : w_q[`W_XPF_LO];
  assign ybase = r.ypf.sel_hi ? w_q[`W_YPF_HI] : w_q[`W_YPF_LO];
  assign xpf_addr_o = r.xpf.idx ? w_q[`W_XPF_HI] + w_q[`W_PF_INDEX] : xbase; // RULE_08
  assign ypf_addr_o = r.ypf.idx ? w_q[`W_YPF_HI] + w_q[`W_PF_INDEX] : ybase; // RULE_09
  assign xpf_rd_o = take && (r.op == OP_MAC || r.op == OP_SQR) && r.xpf.en;
  assign ypf_rd_o = take && (r.op == OP_MAC || r.op == OP_SQR) && r.ypf.en;

  // Source read strobe is combinational so data returns in the same cycle
  always_comb
  begin
    src_mem_o = '0;
    src_mem_o.addr = src_ea;
    src_mem_o.rd = r.valid && ready_o && src_mem &&
                   (r.form == FM_REG || r.op == OP_ADDACC || r.op == OP_ASR1 || r.op == OP_BIT_CLEAR_OP);
  end

  // Illegal operand combinations are refused whole
  always_comb
  begin
    bad = 1'b0;
    if ((r.src_mode == AM_BASEOFS || r.dst_mode == AM_BASEOFS) && r.op != OP_ADDACC)
      bad = 1'b1;                                                    // RULE_04
    unique case (r.op)
      OP_DIV:  bad = bad | src_mem | dst_mem;                        // RULE_05
      OP_SQR:  bad = bad | !in_mul_f(r.wb);                          // RULE_06
      OP_MAC:  bad = bad | !in_mul_f(r.wb) | !in_mul_f(r.ws) | (r.wb >= r.ws); // RULE_07
      default: bad = bad;
    endcase
    if (r.op == OP_MAC || r.op == OP_SQR)
    begin
      if (r.xpf.en && ((r.xpf.idx && !r.xpf.sel_hi) || r.xpf.adj == `ADJ_ILLEGAL))
        bad = 1'b1;                                                  // RULE_08
      if (r.ypf.en && ((r.ypf.idx && !r.ypf.sel_hi) || r.ypf.adj == `ADJ_ILLEGAL))
        bad = 1'b1;                                                  // RULE_09
    end
  end

  assign take = r.valid && ready_o && !bad;

  // ************************************************************
  // Arithmetic and logic
  // ************************************************************
  always_comb
  begin
    unique case (r.form)
      FM_FILE, FM_FILE_W0:
      begin
        op_a = r.file_data;
        op_b = w_q[`W_IMPLICIT];                                     // RULE_02
      end
      FM_TEN_BIT_LITERAL:
      begin
        op_a = w_q[r.wd];
        op_b = {6'h00, r.lit};
      end
      FM_FIVE_BIT_LITERAL:
      begin
        op_a = w_q[r.wb];
        op_b = {11'h000, r.lit[4:0]};
      end
      default:
      begin
        op_a = w_q[r.wb];
        op_b = src_val;
      end
    endcase
  end

  assign cin = (r.op == OP_ADD_WITH_CARRY_OP) ? flags_q.c : 1'b0;
  assign sum = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, cin};        // RULE_11 RULE_12
  assign nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};

  always_comb
  begin
    logic [15:0] sh_src;
    sh_src = (r.form == FM_FILE || r.form == FM_FILE_W0) ? r.file_data : src_val;
    res = sum[15:0];
    wr_res = 1'b1;
    unique case (r.op)
      OP_AND:  res = op_a & op_b;                                    // RULE_19
      OP_ASR1: res = {sh_src[15], sh_src[15:1]};                     // RULE_14
      OP_ASRW: res = 16'($signed(w_q[r.wb]) >>> w_q[r.ws][3:0]);     // RULE_15
      OP_ASRL: res = 16'($signed(w_q[r.wb]) >>> r.lit[3:0]);         // RULE_16
      OP_BIT_CLEAR_OP: res = sh_src & ~(16'h0001 << r.bit_idx);              // RULE_20
      OP_ADD, OP_ADD_WITH_CARRY_OP: res = sum[15:0];
      default: wr_res = 1'b0;
    endcase
  end

  // ************************************************************
  // Accumulator path
  // ************************************************************
  assign prod = 32'($signed(w_q[r.wb]) * $signed(r.op == OP_SQR ? w_q[r.wb] : w_q[r.ws])); // RULE_06 RULE_07
  assign wide_src = {{8{src_val[15]}}, src_val, 16'h0000};

  always_comb
  begin
    acc_upd = take && (r.op == OP_ADDACC || r.op == OP_MAC || r.op == OP_SQR);
    if (r.op == OP_ADDACC)
    begin
      if (r.shift[3])
        addend = wide_src << (5'h10 - {1'b0, r.shift});              // RULE_13
      else
        addend = 40'($signed(wide_src) >>> r.shift[2:0]);            // RULE_13
    end
    else
      addend = {{8{prod[31]}}, prod};
    acc_sum = {acc_q[r.acc_b][39], acc_q[r.acc_b]} + {addend[39], addend};
    acc_sat = acc_sum[40] != acc_sum[39];
    if (acc_sat)
      acc_new = acc_sum[40] ? 40'h8000000000 : 40'h7FFFFFFFFF;
    else
      acc_new = acc_sum[39:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      dsp_q <= '0;
    end
    else if (acc_upd)
    begin
      acc_q[r.acc_b] <= acc_new;
      // Overflow tracks guard bits; saturation is sticky until reset
      if (r.acc_b)
      begin
        dsp_q.ob <= !(&acc_new[39:31] || ~|acc_new[39:31]);          // RULE_18
        dsp_q.sb <= dsp_q.sb | acc_sat;                              // RULE_18
      end
      else
      begin
        dsp_q.oa <= !(&acc_new[39:31] || ~|acc_new[39:31]);          // RULE_18
        dsp_q.sa <= dsp_q.sa | acc_sat;                              // RULE_18
      end
    end
  end

  // ************************************************************
  // Working register file
  // ************************************************************
  always_comb
  begin
    logic [15:0] step;
    step = '0;
    for (int i = 0; i < `NREGS; i++)
      w_d[i] = w_q[i];
    if (take)
    begin
      if (src_mem && (r.form == FM_REG || r.op == OP_ADDACC || r.op == OP_ASR1 || r.op == OP_BIT_CLEAR_OP))
        w_d[r.ws] = adj_f(r.src_mode, w_q[r.ws]);                    // RULE_03
      if (dst_mem && r.form == FM_REG && r.op != OP_BIT_CLEAR_OP)
        w_d[r.wd] = adj_f(r.dst_mode, w_q[r.wd]);                    // RULE_03
      if ((r.op == OP_MAC || r.op == OP_SQR) && r.xpf.en)
      begin
        step = 16'($signed(r.xpf.adj)) << 1;
        if (!r.xpf.idx)
          w_d[r.xpf.sel_hi ? `W_XPF_HI : `W_XPF_LO] = xbase + step;  // RULE_08
        w_d[`W_MUL_LO + {2'b00, r.xpf.dst}] = xpf_rdata_i;           // RULE_10
      end
      if ((r.op == OP_MAC || r.op == OP_SQR) && r.ypf.en)
      begin
        step = 16'($signed(r.ypf.adj)) << 1;
        if (!r.ypf.idx)
          w_d[r.ypf.sel_hi ? `W_YPF_HI : `W_YPF_LO] = ybase + step;  // RULE_09
        w_d[`W_MUL_LO + {2'b00, r.ypf.dst}] = ypf_rdata_i;           // RULE_10
      end
      // The result write comes last so it wins over a pointer adjust
      if (wr_res)
      begin
        if (r.form == FM_FILE_W0)
          w_d[`W_IMPLICIT] = res;                                    // RULE_02
        else if (r.op == OP_BIT_CLEAR_OP && r.form != FM_FILE && !src_mem)
          w_d[r.ws] = res;                                           // RULE_20
        else if (r.op == OP_ASRW || r.op == OP_ASRL || r.form == FM_TEN_BIT_LITERAL)
          w_d[r.wd] = res;
        else if (r.form != FM_FILE && r.op != OP_BIT_CLEAR_OP && !dst_mem)
          w_d[r.wd] = res;                                           // RULE_01
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    for (int i = 0; i < `NREGS; i++)
      w_q[i] <= rst_i ? 16'h0000 : w_d[i];
  end

  always_ff @(posedge clk_sys_i)
  begin
    implicit_working_reg0_data_o <= rst_i ? 16'h0000 : w_q[implicit_working_reg0_sel_i];
  end

  // ************************************************************
  // Result writes to file and data space
  // ************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      file_we_o <= 1'b0;
      file_wdata_o <= 16'h0000;
      dst_mem_o <= '0;
    end
    else
    begin
      file_we_o <= take && wr_res && r.form == FM_FILE;              // RULE_11
      file_wdata_o <= res;
      dst_mem_o.rd <= 1'b0;
      dst_mem_o.wdata <= res;
      if (r.op == OP_BIT_CLEAR_OP)
      begin
        dst_mem_o.wr <= take && r.form != FM_FILE && src_mem;        // RULE_20
        dst_mem_o.addr <= src_ea;
      end
      else
      begin
        dst_mem_o.wr <= take && wr_res && r.form == FM_REG && dst_mem
                        && r.op != OP_ASRW && r.op != OP_ASRL;       // RULE_03
        dst_mem_o.addr <= dst_ea;
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flags_q <= '0;
    else if (take)
    begin
      unique case (r.op)
        OP_ADD, OP_ADD_WITH_CARRY_OP:
        begin
          flags_q.c  <= sum[16];                                     // RULE_17
          flags_q.dc <= nib[4];
          flags_q.n  <= sum[15];
          flags_q.ov <= (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
          flags_q.z  <= (sum[15:0] == 16'h0000);
        end
        OP_ASR1:
        begin
          flags_q.c  <= r.form inside {FM_FILE, FM_FILE_W0} ? r.file_data[0] : src_val[0]; // RULE_14
          flags_q.n  <= res[15];
          flags_q.ov <= 1'b0;
          flags_q.z  <= (res == 16'h0000);
        end
        OP_AND, OP_ASRW, OP_ASRL:
        begin
          flags_q.n <= res[15];                                      // RULE_15 RULE_16 RULE_19
          flags_q.z <= (res == 16'h0000);
        end
        default: flags_q <= flags_q;                                 // RULE_20 RULE_21
      endcase
    end
  end

  assign flags_o = flags_q;
  assign dsp_flags_o = dsp_q;
  assign acc_a_o = acc_q[0];
  assign acc_b_o = acc_q[1];

  // ************************************************************
  // Sequencing, divide hand-off and refusals
  // ************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_RUN;
      branch_taken_o <= 1'b0;
    end
    else
    begin
      branch_taken_o <= take && r.op == OP_BRC && flags_q.c;         // RULE_21
      unique case (state_q)
        ST_RUN:
          if (take && r.op == OP_BRC && flags_q.c)
            state_q <= ST_BR_WAIT;                                   // RULE_21
        ST_BR_WAIT:
          state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_start_o <= 1'b0;
      div_dividend_o <= 16'h0000;
      div_divisor_o <= 16'h0000;
      illegal_o <= 1'b0;
    end
    else
    begin
      div_start_o <= take && r.op == OP_DIV;                         // RULE_05
      div_dividend_o <= w_q[r.wb];
      div_divisor_o <= w_q[r.ws];
      illegal_o <= r.valid && ready_o && bad;
    end
  end

endmodule : dsc_operand_alu_datapath

// [testbench/dsc_alu_assertions.sv]
// Port checks for the operand and ALU datapath
module dsc_alu_assertions
  import dsc_alu_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire op_req_t    req_i,
  input wire logic       ready_o,
  input wire mcu_flags_t flags_o,
  input wire dsp_flags_t dsp_flags_o,
  input wire logic       div_start_o,
  input wire logic       branch_taken_o,
  input wire logic       illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic    take;
  alu_op_t op;
  assign take = req_i.valid && ready_o;
  assign op = req_i.op;
  default clocking dflt_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ****************************************
  // Flag side effects, branch timing and operand refusals
  // ****************************************
  a_and_keeps_cov:
    assert property (take && op == OP_AND |=> $stable(flags_o.c) && $stable(flags_o.dc) && $stable(flags_o.ov))
      else $error("And changed carry or overflow");
  a_bit_clear_op_keeps_flags:
    assert property (take && op == OP_BIT_CLEAR_OP |=> $stable(flags_o) && $stable(dsp_flags_o))
      else $error("Bit clear changed a flag");
  a_asrw_keeps_cov:
    assert property (take && op == OP_ASRW |=> $stable(flags_o.c) && $stable(flags_o.dc) && $stable(flags_o.ov))
      else $error("Register count shift changed carry or overflow");
  a_asrl_keeps_cov:
    assert property (take && op == OP_ASRL |=> $stable(flags_o.c) && $stable(flags_o.ov))
      else $error("Literal count shift changed carry or overflow");
  a_accum_keeps_core:
    assert property (take && op == OP_ADDACC |=> $stable(flags_o))
      else $error("Accumulator add changed a core flag");
  a_branch_two_cycles:
    assert property (take && op == OP_BRC && flags_o.c |=> !ready_o && branch_taken_o && $stable(flags_o) ##1 ready_o)
      else $error("Taken carry branch did not last two cycles");
  a_branch_one_cycle:
    assert property (take && op == OP_BRC && !flags_o.c |=> ready_o && !branch_taken_o && $stable(flags_o))
      else $error("Untaken carry branch stalled or changed flags");
  a_sqr_range:
    assert property (take && op == OP_SQR && (req_i.wb < 4'h4 || req_i.wb > 4'h7) |=> illegal_o)
      else $error("Square outside registers 4 to 7 accepted");
  a_mac_pairs:
    assert property (take && op == OP_MAC && (req_i.wb < 4'h4 || req_i.ws > 4'h7 || req_i.wb >= req_i.ws) |=> illegal_o)
      else $error("Multiply pair outside the allowed set accepted");
  a_div_direct:
    assert property (take && op == OP_DIV && (req_i.src_mode != AM_DIR || req_i.dst_mode != AM_DIR)
                     |=> illegal_o && !div_start_o)
      else $error("Divide with indirect operand accepted");
  a_baseofs_refused:
    assert property (take && op != OP_ADDACC && (req_i.src_mode == AM_BASEOFS || req_i.dst_mode == AM_BASEOFS)
                     |=> illegal_o)
      else $error("Base offset mode accepted outside accumulator add");
endmodule : dsc_alu_assertions

// [testbench/dsc_mem_model.sv]
// Data memory model behind the operand and prefetch ports
module dsc_mem_model
  import dsc_alu_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire mem_req_t    src_mem_o,
  output logic [15:0]      src_rdata_i,
  input  wire mem_req_t    dst_mem_o,
  input  wire logic [15:0] xpf_addr_o,
  input  wire logic        xpf_rd_o,
  output logic [15:0]      xpf_rdata_i,
  input  wire logic [15:0] ypf_addr_o,
  input  wire logic        ypf_rd_o,
  output logic [15:0]      ypf_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [256];
  logic [15:0] junk_q = 16'h0000;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_q[i] = 16'h5A00 | 16'(i);
  end
  // Unread lines toggle each cycle, so data taken outside a read shows up
  always @(posedge clk_sys_i)
  begin
    junk_q <= ~junk_q;
    if (dst_mem_o.wr)
      mem_q[dst_mem_o.addr[8:1]] <= dst_mem_o.wdata;
  end
  assign src_rdata_i = src_mem_o.rd ? mem_q[src_mem_o.addr[8:1]] : junk_q;
  assign xpf_rdata_i = xpf_rd_o ? mem_q[xpf_addr_o[8:1]] : junk_q;
  assign ypf_rdata_i = ypf_rd_o ? mem_q[ypf_addr_o[8:1]] : ~junk_q;
endmodule : dsc_mem_model

// [testbench/testbench.sv]
// Self-checking testbench of the operand and ALU datapath
module testbench
  import dsc_alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_i, ready_o, xpf_rd_o, ypf_rd_o, file_we_o, div_start_o, branch_taken_o, illegal_o;
  logic [15:0] src_rdata_i, xpf_addr_o, xpf_rdata_i, ypf_addr_o, ypf_rdata_i, file_wdata_o;
  logic [15:0] div_dividend_o, div_divisor_o, implicit_working_reg0_data_o;
  logic [39:0] acc_a_o, acc_b_o;
  logic [3:0]  implicit_working_reg0_sel_i;
  op_req_t     req_i;
  mem_req_t    src_mem_o, dst_mem_o;
  mcu_flags_t  flags_o;
  dsp_flags_t  dsp_flags_o;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  dsc_operand_alu_datapath dsc_operand_alu_datapath_i (
    .clk_sys_i, .rst_i, .req_i, .ready_o, .src_mem_o, .src_rdata_i, .dst_mem_o, .xpf_addr_o, .xpf_rd_o,
    .xpf_rdata_i, .ypf_addr_o, .ypf_rd_o, .ypf_rdata_i, .file_wdata_o, .file_we_o, .flags_o, .dsp_flags_o,
    .acc_a_o, .acc_b_o, .div_start_o, .div_dividend_o, .div_divisor_o, .branch_taken_o, .illegal_o,
    .implicit_working_reg0_sel_i, .implicit_working_reg0_data_o);
  dsc_mem_model dsc_mem_model_i (.clk_sys_i, .src_mem_o, .src_rdata_i, .dst_mem_o, .xpf_addr_o, .xpf_rd_o,
    .xpf_rdata_i, .ypf_addr_o, .ypf_rd_o, .ypf_rdata_i);
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bit1(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask : bit1
  task automatic flg(input logic [4:0] e);
    chk({11'h000, flags_o}, {11'h000, e});
  endtask : flg
  function automatic op_req_t mk(alu_op_t op, form_t fm, logic [3:0] wb, logic [3:0] ws, logic [3:0] wd);
    op_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.form = fm;
    r.wb = wb;
    r.ws = ws;
    r.wd = wd;
    return r;
  endfunction : mk
  // One idle cycle between requests; results are sampled just after the taking edge
  task automatic issue(input op_req_t r);
    @(posedge clk_sys_i);
    req_i <= r;
    @(posedge clk_sys_i);
    req_i <= '0;
    #1;
  endtask : issue
  task automatic ld(input logic [3:0] wd, input logic [9:0] lit);
    op_req_t r;
    r = mk(OP_ADD, FM_TEN_BIT_LITERAL, 4'h0, 4'h0, wd);
    r.lit = lit;
    issue(r);
  endtask : ld
  task automatic fop(input alu_op_t op, input form_t fm, input logic [15:0] fd);
    op_req_t r;
    r = mk(op, fm, 4'h0, 4'h0, 4'h0);
    r.file_data = fd;
    issue(r);
  endtask : fop
  task automatic rdw(input logic [3:0] n, input logic [15:0] exp);
    @(posedge clk_sys_i);
    implicit_working_reg0_sel_i <= n;
    @(posedge clk_sys_i);
    #1;
    chk(implicit_working_reg0_data_o, exp);
  endtask : rdw
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start();
    ld(4'h1, 10'h3FF);
    ld(4'h2, 10'h001);
    issue(mk(OP_ADD, FM_REG, 4'h1, 4'h2, 4'h3));
    flg(5'h08);
    rdw(4'h3, 16'h0400);
    fop(OP_ADD, FM_FILE_W0, 16'hFFFF);
    flg(5'h04);
    fop(OP_ADD, FM_FILE, 16'h0001);
    bit1(file_we_o, 1'b1);
    chk(file_wdata_o, 16'h0000);
    flg(5'h19);
    fop(OP_ADD_WITH_CARRY_OP, FM_FILE_W0, 16'h0001);
    flg(5'h18);
    rdw(4'h0, 16'h0001);
  endtask : t_start
  task automatic t_shift();
    op_req_t r;
    r = mk(OP_AND, FM_TEN_BIT_LITERAL, 4'h0, 4'h0, 4'h3);
    r.lit = 10'h0FF;
    issue(r);
    flg(5'h19);
    fop(OP_ASR1, FM_FILE_W0, 16'h8001);
    flg(5'h1C);
    rdw(4'h0, 16'hC000);
    issue(mk(OP_ASRW, FM_REG, 4'h1, 4'h2, 4'h7));
    flg(5'h18);
    rdw(4'h7, 16'h01FF);
    r = mk(OP_ASRL, FM_REG, 4'h0, 4'h0, 4'h6);
    r.lit = 10'h004;
    issue(r);
    flg(5'h1C);
    r = mk(OP_BIT_CLEAR_OP, FM_REG, 4'h0, 4'h6, 4'h0);
    r.bit_idx = 4'hF;
    issue(r);
    flg(5'h1C);
    rdw(4'h6, 16'h7C00);
  endtask : t_shift
  task automatic t_branch();
    issue(mk(OP_BRC, FM_REG, 4'h0, 4'h0, 4'h0));
    bit1(ready_o, 1'b0);
    bit1(branch_taken_o, 1'b1);
    ld(4'h9, 10'h000);
    issue(mk(OP_BRC, FM_REG, 4'h0, 4'h0, 4'h0));
    bit1(ready_o, 1'b1);
    bit1(branch_taken_o, 1'b0);
    flg(5'h01);
  endtask : t_branch
  task automatic t_refuse();
    op_req_t bad [4];
    bad[0] = mk(OP_SQR, FM_REG, 4'h3, 4'h3, 4'h0);
    bad[1] = mk(OP_MAC, FM_REG, 4'h5, 4'h4, 4'h0);
    bad[2] = mk(OP_DIV, FM_REG, 4'h1, 4'h7, 4'h0);
    bad[2].src_mode = AM_IND;
    bad[3] = mk(OP_ADD, FM_REG, 4'h1, 4'h2, 4'h3);
    bad[3].src_mode = AM_BASEOFS;
    foreach (bad[i])
    begin
      issue(bad[i]);
      bit1(illegal_o, 1'b1);
    end
    rdw(4'h3, 16'h0000);
    issue(mk(OP_DIV, FM_REG, 4'h1, 4'h7, 4'h0));
    bit1(div_start_o, 1'b1);
    chk(div_dividend_o, 16'h03FF);
    chk(div_divisor_o, 16'h01FF);
  endtask : t_refuse
  task automatic t_operands();
    op_req_t r;
    ld(4'hA, 10'h020);
    r = mk(OP_ADD, FM_REG, 4'h1, 4'hA, 4'hB);
    r.src_mode = AM_POSTINC;
    issue(r);
    rdw(4'hB, 16'h5E0F);
    rdw(4'hA, 16'h0022);
    r = mk(OP_ADD, FM_REG, 4'h1, 4'h2, 4'h3);
    r.dst_mode = AM_PREDEC;
    issue(r);
    bit1(dst_mem_o.wr, 1'b1);
    chk(dst_mem_o.addr, 16'hFFFE);
    chk(dst_mem_o.wdata, 16'h0400);
    r = mk(OP_ADDACC, FM_REG, 4'h0, 4'h2, 4'h0);
    r.acc_b = 1'b1;
    r.shift = 4'hF;
    issue(r);
    chk(acc_b_o[31:16], 16'h0002);
    chk({12'h000, dsp_flags_o}, 16'h0000);
    ld(4'h8, 10'h010);
    r = mk(OP_MAC, FM_REG, 4'h4, 4'h5, 4'h0);
    r.xpf.en = 1'b1;
    r.xpf.adj = 3'h1;
    r.ypf.en = 1'b1;
    r.ypf.adj = 3'h7;
    r.ypf.dst = 2'h3;
    issue(r);
    rdw(4'h8, 16'h0012);
    rdw(4'hA, 16'h0020);
    rdw(4'h4, 16'h5A08);
    rdw(4'h7, 16'h5A11);
    // Two large left-shifted adds drive accumulator A into positive saturation
    r = mk(OP_ADDACC, FM_REG, 4'h0, 4'hB, 4'h0);
    r.shift = 4'h8;
    repeat (2) issue(r);
    chk(acc_a_o[39:24], 16'h7FFF);
    chk({12'h000, dsp_flags_o}, 16'h000A);
    ld(4'hF, 10'h155);
    rdw(4'hF, 16'h0155);
  endtask : t_operands
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      $display("Error at %0t: run did not finish", $time);
      summarize();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    req_i = '0;
    implicit_working_reg0_sel_i = 4'h0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_start();
    t_shift();
    t_branch();
    t_refuse();
    t_operands();
    summarize();
  end
endmodule : testbench
bind dsc_operand_alu_datapath dsc_alu_assertions dsc_alu_assertions_i (.clk_sys_i, .rst_i, .req_i, .ready_o,
  .flags_o, .dsp_flags_o, .div_start_o, .branch_taken_o, .illegal_o);
